// file: common/rsi_cfg.svh
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH

// execution start point after cold reset and soft init
`define RSI_RESET_VECTOR   32'hFFFF_FFF0
// self test length in bus clocks
`define RSI_BUILTIN_SELF_TEST_CYCLES    16'h0040
// bus clock period
`define RSI_CLK_NS         100
// power-on reset hold, kept by system logic
`define RSI_POR_MIN_NS     1000000
`define RSI_POR_MIN_CYC    ((`RSI_POR_MIN_NS + `RSI_CLK_NS - 1) / `RSI_CLK_NS)
// warm reset hold, kept by system logic
`define RSI_WARM_MIN_CYC   15
// strap field widths
`define RSI_RATIO_W        3

`endif

// file: common/rsi_pkg.sv
`default_nettype none
package rsi_pkg;

  typedef enum logic [2:0] {
    RSI_ST_RESET,
    RSI_ST_BUILTIN_SELF_TEST,
    RSI_ST_RUN,
    RSI_ST_TEST
  } rsi_state_t;

  // internal clear strobes toward the core
  typedef struct packed {
    logic pipe;
    logic arch;
    logic cache;
    logic fpu_mm;
    logic msr;
    logic cdnw;
    logic tsc;
  } rsi_clr_t;

  // processor output pins, values and enables
  typedef struct packed {
    logic [31:3] addr;
    logic        address_parity;
    logic        addr_oe;
    logic [7:0]  byte_enables_n;
    logic        be_oe;
    logic [63:0] data;
    logic [7:0]  data_parity;
    logic        data_oe;
    logic        tdo;
    logic        tdo_oe;
    logic        address_strobe_n;
    logic        address_strobe_copy_n;
    logic        addr_parity_check_n;
    logic        data_parity_check_n;
    logic        cache_n;
    logic        fpu_error_n;
    logic        hit_n;
    logic        hit_modified_n;
    logic        lock_n;
    logic        sysmgmt_active_n;
    logic        bus_request_out;
    logic        data_code;
    logic        hold_acknowledge;
    logic        mem_io;
    logic        page_cache_disable;
    logic        page_write_through;
    logic        split_cycle;
    logic        write_read;
    logic        core_volt_detect;
    logic        core_volt_level_sel;
  } rsi_pins_t;

endpackage : rsi_pkg
`default_nettype wire

// file: logic/rsi_cnt.sv
`default_nettype none
module rsi_cnt #(
  parameter logic [15:0] LEN = 16'h0040
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // control
  input  wire logic start_i,
  input  wire logic abort_i,
  // status
  output var  logic busy_o,
  output var  logic done_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        busy_nxt;
  logic        done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_o;
    done_nxt = 1'b0;
    if (abort_i)
    begin
      busy_nxt = 1'b0;
      cnt_nxt  = 16'h0000;
    end
    else if (start_i)
    begin
      busy_nxt = 1'b1;
      cnt_nxt  = LEN;
    end
    else if (busy_o)
    begin
      if (cnt_r <= 16'h0001)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        cnt_nxt  = 16'h0000;
      end
      else
      begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r  <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_o <= busy_nxt;
      done_o <= done_nxt;
    end
  end

endmodule : rsi_cnt
`default_nettype wire

// file: logic/rsi_ctrl.sv
`include "rsi_cfg.svh"
`default_nettype none
module rsi_ctrl #(
  parameter logic [15:0] BUILTIN_SELF_TEST_LEN = `RSI_BUILTIN_SELF_TEST_CYCLES
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  // system control inputs
  input  wire logic                      reset_i,
  input  wire logic                      init_i,
  // straps sampled at the fall of reset_i
  input  wire logic                      flush_strap_n_i,
  input  wire logic [`RSI_RATIO_W-1:0]   core_clock_ratio_sel_i,
  input  wire logic                      burst_ready_copy_n_i,
  // core side
  input  wire logic                      instr_boundary_i,
  input  wire rsi_pkg::rsi_pins_t        core_pins_i,
  // pins toward the system bus
  output var  rsi_pkg::rsi_pins_t        pins_o,
  // core control
  output var  rsi_pkg::rsi_clr_t         clr_o,
  output var  logic                      fetch_start_o,
  output var  logic [31:0]               fetch_addr_o,
  output var  logic                      running_o,
  // configuration and status
  output var  logic [`RSI_RATIO_W-1:0]   core_ratio_o,
  output var  logic                      hi_drive_o,
  output var  logic                      tri_test_o,
  output var  logic                      builtin_self_test_busy_o,
  output var  logic                      init_pend_o
);
  import rsi_pkg::*;

  // pin levels forced while reset is seen
  function automatic rsi_pins_t reset_pins(input rsi_pins_t p);
    rsi_pins_t q;
    q = p;
    q.addr_oe = 1'b0;
    q.be_oe   = 1'b0;
    q.data_oe = 1'b0;
    q.tdo_oe  = 1'b0;
    q.address_strobe_n      = 1'b1;
    q.address_strobe_copy_n = 1'b1;
    q.addr_parity_check_n   = 1'b1;
    q.data_parity_check_n   = 1'b1;
    q.cache_n               = 1'b1;
    q.fpu_error_n           = 1'b1;
    q.hit_n                 = 1'b1;
    q.hit_modified_n        = 1'b1;
    q.lock_n                = 1'b1;
    q.sysmgmt_active_n      = 1'b1;
    q.bus_request_out     = 1'b0;
    q.data_code           = 1'b0;
    q.hold_acknowledge    = 1'b0;
    q.mem_io              = 1'b0;
    q.page_cache_disable  = 1'b0;
    q.page_write_through  = 1'b0;
    q.split_cycle         = 1'b0;
    q.write_read          = 1'b0;
    q.core_volt_detect    = 1'b0;
    q.core_volt_level_sel = 1'b0;
    return q;
  endfunction : reset_pins

  localparam rsi_pins_t PINS_RST = reset_pins('0);
  localparam rsi_clr_t  CLR_ALL  = '1;
  localparam rsi_clr_t  CLR_SOFT = '{pipe: 1'b1, arch: 1'b1, default: 1'b0};

  rsi_state_t                  state_r;
  rsi_state_t                  state_nxt;
  logic                        reset_q_r;
  logic                        init_pend_nxt;
  rsi_pins_t                   pins_nxt;
  rsi_clr_t                    clr_nxt;
  logic                        fetch_nxt;
  logic [`RSI_RATIO_W-1:0]     ratio_nxt;
  logic                        hi_drive_nxt;
  logic                        tri_test_nxt;
  logic                        reset_fall;
  logic                        builtin_self_test_start;
  logic                        builtin_self_test_busy;
  logic                        builtin_self_test_done;
  logic                        soft_take;

  assign reset_fall = reset_q_r & ~reset_i;
  // normal start always passes through self test
  assign builtin_self_test_start = reset_fall & flush_strap_n_i;
  // a pending or same-cycle request is honoured only between instructions
  assign soft_take  = (state_r == RSI_ST_RUN) & instr_boundary_i
                    & (init_pend_o | init_i);

  rsi_cnt #(
    .LEN     (BUILTIN_SELF_TEST_LEN)
  ) u_builtin_self_test (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (builtin_self_test_start),
    .abort_i (reset_i),
    .busy_o  (builtin_self_test_busy),
    .done_o  (builtin_self_test_done)
  );

  always_comb
  begin
    state_nxt     = state_r;
    init_pend_nxt = init_pend_o;
    clr_nxt       = '0;
    fetch_nxt     = 1'b0;
    ratio_nxt     = core_ratio_o;
    hi_drive_nxt  = hi_drive_o;
    tri_test_nxt  = tri_test_o;
    pins_nxt      = core_pins_i;
    case (state_r)
      RSI_ST_RESET:
      begin
        // keep pins parked on the fall edge so test mode never drives
        pins_nxt = reset_pins(core_pins_i);
        if (reset_fall)
        begin
          ratio_nxt    = core_clock_ratio_sel_i;
          hi_drive_nxt = ~burst_ready_copy_n_i;
          tri_test_nxt = ~flush_strap_n_i;
          state_nxt    = flush_strap_n_i ? RSI_ST_BUILTIN_SELF_TEST : RSI_ST_TEST;
        end
      end
      RSI_ST_BUILTIN_SELF_TEST:
      begin
        if (builtin_self_test_done)
        begin
          fetch_nxt = 1'b1;
          state_nxt = RSI_ST_RUN;
        end
      end
      RSI_ST_RUN:
      begin
        // sampling every edge; a request seen while clearing is kept
        if (soft_take)
        begin
          clr_nxt       = CLR_SOFT;
          fetch_nxt     = 1'b1;
          init_pend_nxt = 1'b0;
        end
        else if (init_i)
        begin
          init_pend_nxt = 1'b1;
        end
      end
      RSI_ST_TEST:
      begin
        // tri-state test: address, byte-enable, data and tdo drivers released until the next reset
        pins_nxt.addr_oe = 1'b0;
        pins_nxt.be_oe   = 1'b0;
        pins_nxt.data_oe = 1'b0;
        pins_nxt.tdo_oe  = 1'b0;
      end
      default:
      begin
        state_nxt = RSI_ST_RESET;
      end
    endcase
    // reset wins over every state and drops any pending soft init
    if (reset_i)
    begin
      state_nxt     = RSI_ST_RESET;
      init_pend_nxt = 1'b0;
      clr_nxt       = CLR_ALL;
      fetch_nxt     = 1'b0;
      tri_test_nxt  = 1'b0;
      pins_nxt      = reset_pins(core_pins_i);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r      <= RSI_ST_RESET;
      reset_q_r    <= 1'b1;
      init_pend_o  <= 1'b0;
      clr_o        <= CLR_ALL;
      fetch_start_o <= 1'b0;
      core_ratio_o <= '0;
      hi_drive_o   <= 1'b0;
      tri_test_o   <= 1'b0;
      pins_o       <= PINS_RST;
      builtin_self_test_busy_o  <= 1'b0;
      running_o    <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      reset_q_r    <= reset_i;
      init_pend_o  <= init_pend_nxt;
      clr_o        <= clr_nxt;
      fetch_start_o <= fetch_nxt;
      core_ratio_o <= ratio_nxt;
      hi_drive_o   <= hi_drive_nxt;
      tri_test_o   <= tri_test_nxt;
      pins_o       <= pins_nxt;
      builtin_self_test_busy_o  <= builtin_self_test_busy;
      running_o    <= (state_nxt == RSI_ST_RUN);
    end
  end

  // both restart kinds share one vector, so the address is a constant
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fetch_addr_o <= `RSI_RESET_VECTOR;
    end
    else
    begin
      fetch_addr_o <= `RSI_RESET_VECTOR;
    end
  end

  localparam int BUILTIN_SELF_TEST_MAX = 80;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_fall_normal;
    reset_q_r && !reset_i && flush_strap_n_i;
  endsequence

  sequence s_builtin_self_test_then_fetch;
    builtin_self_test_busy_o [*1] ##[1:BUILTIN_SELF_TEST_MAX] fetch_start_o;
  endsequence

  pins_float_a:
    assert property (reset_i |=> !pins_o.addr_oe && !pins_o.be_oe
                     && !pins_o.data_oe && !pins_o.tdo_oe)
    else $error("bus not floated during reset");

  pins_high_a:
    assert property (reset_i |=> pins_o.address_strobe_n
                     && pins_o.address_strobe_copy_n && pins_o.hit_n
                     && pins_o.hit_modified_n && pins_o.lock_n
                     && pins_o.cache_n && pins_o.fpu_error_n
                     && pins_o.addr_parity_check_n
                     && pins_o.data_parity_check_n
                     && pins_o.sysmgmt_active_n)
    else $error("high pin not driven high in reset");

  pins_low_a:
    assert property (reset_i |=> !(pins_o.bus_request_out
                     || pins_o.data_code || pins_o.hold_acknowledge
                     || pins_o.mem_io || pins_o.page_cache_disable
                     || pins_o.page_write_through || pins_o.split_cycle
                     || pins_o.write_read || pins_o.core_volt_detect
                     || pins_o.core_volt_level_sel))
    else $error("low pin not driven low in reset");

  cold_clear_a:
    assert property (reset_i |=> clr_o == CLR_ALL && !fetch_start_o
                     && !running_o)
    else $error("cold reset did not clear all state");

  soft_keep_a:
    assert property (running_o && clr_o.pipe |->
                     !(clr_o.cache || clr_o.fpu_mm || clr_o.msr
                       || clr_o.cdnw || clr_o.tsc))
    else $error("soft init cleared preserved state");

  soft_restart_a:
    assert property (soft_take && !reset_i |=> fetch_start_o
                     && clr_o == CLR_SOFT
                     ##1 fetch_addr_o == `RSI_RESET_VECTOR)
    else $error("soft init did not restart at vector");

  init_boundary_a:
    assert property (running_o && clr_o.pipe |->
                     $past(instr_boundary_i))
    else $error("soft init taken off an instruction boundary");

  init_hold_a:
    assert property (running_o && init_i && !instr_boundary_i
                     && !reset_i |=> init_pend_o)
    else $error("soft init request lost");

  ratio_cap_a:
    assert property (reset_q_r && !reset_i |=>
                     core_ratio_o == $past(core_clock_ratio_sel_i))
    else $error("clock ratio not captured at reset fall");

  drive_cap_a:
    assert property (reset_q_r && !reset_i |=>
                     hi_drive_o == !$past(burst_ready_copy_n_i))
    else $error("drive strength not captured at reset fall");

  test_entry_a:
    assert property (reset_q_r && !reset_i && !flush_strap_n_i
                     |=> tri_test_o && !running_o && !pins_o.data_oe)
    else $error("tri-state test mode not entered");

  builtin_self_test_run_a:
    assert property (s_fall_normal ##1 !reset_i [*2] |->
                     s_builtin_self_test_then_fetch)
    else $error("self test did not precede execution");

endmodule : rsi_ctrl
`default_nettype wire

// file: verif/rsi_sys_model.sv
`default_nettype none
module rsi_sys_model
  import rsi_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // system control toward the device
  output var  logic       reset_o,
  output var  logic       init_o,
  // straps
  output var  logic       flush_strap_n_o,
  output var  logic [2:0] ratio_o,
  output var  logic       brc_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    reset_o         = 1'b1;
    init_o          = 1'b0;
    flush_strap_n_o = 1'b1;
    ratio_o         = 3'h0;
    brc_n_o         = 1'b1;
  end

  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #10;
    end
  endtask : step

  // callers add holds up to 15 clocks, or the power-on length
  task automatic reset_hold(input int n);
    reset_o = 1'b1;
    step(n);
  endtask : reset_hold

  task automatic reset_drop(input logic fl, input logic [2:0] rt,
                            input logic bc);
    flush_strap_n_o = fl;
    ratio_o         = rt;
    brc_n_o         = bc;
    reset_o         = 1'b0;
    step(1);
    // straps released: inverse shows up so a late capture is caught
    flush_strap_n_o = ~fl;
    ratio_o         = ~rt;
    brc_n_o         = ~bc;
  endtask : reset_drop

  task automatic init_sync();
    init_o = 1'b1;
    step(1);
    init_o = 1'b0;
  endtask : init_sync

  task automatic init_async();
    init_o = 1'b0;
    step(2);
    init_o = 1'b1;
    step(2);
    init_o = 1'b0;
  endtask : init_async
endmodule : rsi_sys_model
`default_nettype wire

// file: verif/test_cpu_reset_init_control.sv
`include "rsi_cfg.svh"
`default_nettype none
module test_cpu_reset_init_control;
  import rsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] BUILTIN_SELF_TEST = 16'h0004;
  logic             clk_i;
  logic             rstn_i;
  logic             reset_i;
  logic             init_i;
  logic             flush_n;
  logic [2:0]       ratio;
  logic             brc_n;
  logic             boundary;
  rsi_pins_t        core_pins;
  rsi_pins_t        pins_o;
  rsi_clr_t         clr_o;
  logic             fetch_start_o;
  logic [31:0]      fetch_addr_o;
  logic             running_o;
  logic [2:0]       core_ratio_o;
  logic             hi_drive_o;
  logic             tri_test_o;
  logic             builtin_self_test_busy_o;
  logic             init_pend_o;
  int               n_fail;
  int               n_compared;
  int               cnt;

  rsi_ctrl #(.BUILTIN_SELF_TEST_LEN(BUILTIN_SELF_TEST)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .reset_i(reset_i), .init_i(init_i),
    .flush_strap_n_i(flush_n), .core_clock_ratio_sel_i(ratio),
    .burst_ready_copy_n_i(brc_n), .instr_boundary_i(boundary),
    .core_pins_i(core_pins), .pins_o(pins_o), .clr_o(clr_o),
    .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o),
    .running_o(running_o), .core_ratio_o(core_ratio_o),
    .hi_drive_o(hi_drive_o), .tri_test_o(tri_test_o),
    .builtin_self_test_busy_o(builtin_self_test_busy_o), .init_pend_o(init_pend_o));

  rsi_sys_model i_sys (
    .clk_i(clk_i), .reset_o(reset_i), .init_o(init_i),
    .flush_strap_n_o(flush_n), .ratio_o(ratio), .brc_n_o(brc_n));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #10;
    end
  endtask : step

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic miss(input logic [159:0] g, input logic [159:0] e);
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
  endtask : miss

  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e)
      miss(160'(g), 160'(e));
  endtask : chk1

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
      miss(160'(g), 160'(e));
  endtask : chk32

  task automatic chkp(input rsi_pins_t g, input rsi_pins_t e);
    n_compared++;
    if (g !== e)
      miss(160'(g), 160'(e));
  endtask : chkp

  function automatic rsi_pins_t rst_pins();
    rsi_pins_t p;
    // floated pins keep whatever value the core offers; only enables matter
    p = core_pins;
    {p.addr_oe, p.be_oe, p.data_oe, p.tdo_oe} = 4'h0;
    {p.address_strobe_n, p.address_strobe_copy_n, p.addr_parity_check_n,
     p.data_parity_check_n, p.cache_n, p.fpu_error_n, p.hit_n,
     p.hit_modified_n, p.lock_n, p.sysmgmt_active_n} = 10'h3ff;
    {p.bus_request_out, p.data_code, p.hold_acknowledge, p.mem_io,
     p.page_cache_disable, p.page_write_through, p.split_cycle,
     p.write_read, p.core_volt_detect, p.core_volt_level_sel} = 10'h000;
    return p;
  endfunction : rst_pins

  task automatic rand_pins();
    for (int b = 0; b < $bits(rsi_pins_t); b++)
      core_pins[b] = 1'($urandom_range(1, 0));
  endtask : rand_pins

  // counts fetch pulses over a window; soft restarts clear only pipe+arch
  task automatic count_fetch(input int win, input logic [6:0] eclr);
    cnt = 0;
    repeat (win)
    begin
      step(1);
      if (fetch_start_o === 1'b1)
      begin
        cnt++;
        chk32(32'(clr_o), 32'(eclr));
        chk32(fetch_addr_o, `RSI_RESET_VECTOR);
      end
    end
  endtask : count_fetch

  task automatic boot(input logic fl, input logic [2:0] rt,
                      input logic bc);
    i_sys.reset_hold(2);
    chkp(pins_o, rst_pins());
    chk32(32'(clr_o), 32'h0000_007f);
    chk1(running_o, 1'b0);
    i_sys.reset_hold(13);
    i_sys.reset_drop(fl, rt, bc);
    step(1);
    chk32(32'(core_ratio_o), 32'(rt));
    chk1(hi_drive_o, ~bc);
    chk1(tri_test_o, ~fl);
    chk1(builtin_self_test_busy_o, fl);
    if (fl)
    begin
      cnt = 0;
      while (fetch_start_o !== 1'b1 && cnt < 40)
      begin
        step(1);
        cnt++;
      end
      chk1(32'(cnt) >= 32'(BUILTIN_SELF_TEST), 1'b1);
      chk1(fetch_start_o, 1'b1);
      chk32(fetch_addr_o, `RSI_RESET_VECTOR);
      chk1(running_o, 1'b1);
      chk1(builtin_self_test_busy_o, 1'b0);
      if (cnt >= 40)
        stop_test();
    end
  endtask : boot

  initial
  begin
    n_fail     = 0;
    n_compared = 0;
    rstn_i     = 1'b0;
    boundary   = 1'b0;
    core_pins  = '0;
    void'($urandom(86));
    repeat (12) @(posedge clk_i);
    #10;
    rstn_i = 1'b1;
    i_sys.reset_hold(`RSI_POR_MIN_CYC);
    for (int r = 0; r < 8; r++)
      boot(1'b1, 3'(r), 1'($urandom_range(1, 0)));
    rand_pins();
    step(2);
    chkp(pins_o, core_pins);
    for (int k = 0; k < 2; k++)
    begin
      boundary = 1'b0;
      if (k == 0)
        i_sys.init_sync();
      else
        i_sys.init_async();
      repeat (3)
      begin
        step(1);
        chk1(init_pend_o, 1'b1);
        chk1(fetch_start_o, 1'b0);
      end
      // boundary comes three edges after init, as after an I/O write
      boundary = 1'b1;
      count_fetch(6, 7'h60);
      chk32(32'(cnt), 32'h0000_0001);
      chk1(init_pend_o, 1'b0);
      chk1(running_o, 1'b1);
    end
    boot(1'b0, 3'($urandom_range(7, 0)), 1'b0);
    chk1(running_o, 1'b0);
    rand_pins();
    step(2);
    chk32({28'h000_0000, pins_o.addr_oe, pins_o.be_oe, pins_o.data_oe,
           pins_o.tdo_oe}, 32'h0000_0000);
    i_sys.init_sync();
    count_fetch(6, 7'h60);
    chk32(32'(cnt), 32'h0000_0000);
    boot(1'b1, 3'h5, 1'b1);
    stop_test();
  end
endmodule : test_cpu_reset_init_control
`default_nettype wire
